// >>> verilog/dcd_pkg.sv
// package for the dual input clock divider
package dcd_pkg;

	// ----------------------------------------------------------------
	// source select encoding
	// ----------------------------------------------------------------
	localparam logic SEL_ECL = 1'b0;
	localparam logic SEL_TTL = 1'b1;

	// ----------------------------------------------------------------
	// output reset levels and divider layout
	// ----------------------------------------------------------------
	localparam logic TRUE_RESET_LEVEL = 1'b0;
	localparam logic COMP_RESET_LEVEL = 1'b1;
	localparam int DIV_WIDTH = 2;
	localparam logic [1:0] DIV_RESET = 2'h0;
	localparam int DIV2_BIT = 0;
	localparam int DIV4_BIT = 1;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// synchroniser bit positions
	// ----------------------------------------------------------------
	localparam int SYNC_ECL_P = 0;
	localparam int SYNC_ECL_N = 1;
	localparam int SYNC_TTL = 2;
	localparam int SYNC_SEL = 3;
	localparam int SYNC_OPEN = 4;
	localparam int SYNC_RST_N = 5;
	localparam int SYNC_COUNT = 6;

	// one true/complement output pair
	typedef struct packed {
		logic true_out;
		logic comp_out;
	} dcd_pair_t;

endpackage : dcd_pkg

// >>> verilog/dcd_divider.sv
// dual input clock divider: source select, divide by two and four, paired outputs
// Summary of operation
// - reset low forces true outputs low and complementary outputs high, asynchronously
// - divide-by-two and divide-by-four rising edges line up after power-up
// - select low picks the differential pair, high picks the single-ended input
// - both divider stages count the selected input, so output duty is symmetric
// - an open differential pair settles to true low, complement high
`timescale 1ns/1ps
module dcd_divider
	import dcd_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	// clock sources, select and device reset
	input wire logic ECL_PAIR_INPUT_P_I,
	input wire logic ECL_PAIR_INPUT_N_I,
	input wire logic ECL_PAIR_OPEN_I,
	input wire logic TTL_SINGLE_INPUT_I,
	input wire logic SOURCE_SELECT_I,
	input wire logic RESET_N_I,
	// divided clock outputs
	output logic DIVIDED_CLOCK_OUTPUT_2_O,
	output logic DIVIDED_CLOCK_OUTPUT_2_N_O,
	output logic DIVIDED_CLOCK_OUTPUT_4_O,
	output logic DIVIDED_CLOCK_OUTPUT_4_N_O
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_COUNT-1:0] raw_in;
	logic [SYNC_COUNT-1:0] s1_reg;
	logic [SYNC_COUNT-1:0] s2_reg;
	logic [SYNC_COUNT-1:0] s3_reg;
	logic [SYNC_COUNT-1:0] st_reg;
	logic [SYNC_COUNT-1:0] s1_next;
	logic [SYNC_COUNT-1:0] s2_next;
	logic [SYNC_COUNT-1:0] s3_next;
	logic [SYNC_COUNT-1:0] st_next;

	// every pin is asynchronous to CLOCK_I, the device reset included
	always_comb begin
		raw_in = '0;
		raw_in[SYNC_ECL_P] = ECL_PAIR_INPUT_P_I;
		raw_in[SYNC_ECL_N] = ECL_PAIR_INPUT_N_I;
		raw_in[SYNC_TTL] = TTL_SINGLE_INPUT_I;
		raw_in[SYNC_SEL] = SOURCE_SELECT_I;
		raw_in[SYNC_OPEN] = ECL_PAIR_OPEN_I;
		raw_in[SYNC_RST_N] = RESET_N_I;
	end

	always_comb begin
		s1_next = raw_in;
		s2_next = s1_reg;
		s3_next = s2_reg;
		st_next = st_reg;
		for (int i = 0; i < SYNC_COUNT; i++) begin
			// a change counts once stages two and three agree
			if (s2_reg[i] == s3_reg[i]) begin
				st_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			st_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// decoders
	// ----------------------------------------------------------------
	function automatic logic is_ttl(input logic sel);
		return sel == SEL_TTL;
	endfunction : is_ttl

	// complement is built from the same bit, so a pair cannot skew in logic
	function automatic dcd_pair_t make_pair(input logic level);
		dcd_pair_t pair;
		pair.true_out = level;
		pair.comp_out = ~level;
		return pair;
	endfunction : make_pair

	// ----------------------------------------------------------------
	// source selection
	// ----------------------------------------------------------------
	logic ecl_p;
	logic ecl_n;
	logic ecl_clk;
	logic src_clk;
	logic src_rise;
	logic src_prev_reg;
	logic src_prev_next;

	always_comb begin
		// open pair defaults to a defined low/high state
		ecl_p = st_reg[SYNC_OPEN] ? 1'b0 : st_reg[SYNC_ECL_P];
		ecl_n = st_reg[SYNC_OPEN] ? 1'b1 : st_reg[SYNC_ECL_N];
		// differential receiver: true side above complement
		ecl_clk = ecl_p & ~ecl_n;
		src_clk = is_ttl(st_reg[SYNC_SEL]) ? st_reg[SYNC_TTL] : ecl_clk;
		src_rise = src_clk & ~src_prev_reg;
		src_prev_next = src_clk;
	end

	// edge memory is cleared with the divider so a restart sees no stale edge
	always_ff @(posedge CLOCK_I or posedge RESET_I or negedge RESET_N_I) begin
		if (RESET_I || !RESET_N_I) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_prev_next;
		end
	end

	// ----------------------------------------------------------------
	// divider chain
	// ----------------------------------------------------------------
	logic [DIV_WIDTH-1:0] div_reg;
	logic [DIV_WIDTH-1:0] div_next;
	logic hold;

	// synchronised copy of the device reset keeps the count at zero after release
	assign hold = ~st_reg[SYNC_RST_N];

	always_comb begin
		div_next = div_reg;
		if (hold) begin
			div_next = DIV_RESET;
		end else if (src_rise) begin
			// counting down walks 0, 3, 2, 1: bit 1 only toggles as bit 0 rises
			div_next = div_reg - 2'h1;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I or negedge RESET_N_I) begin
		if (RESET_I || !RESET_N_I) begin
			div_reg <= DIV_RESET;
		end else begin
			div_reg <= div_next;
		end
	end

	// ----------------------------------------------------------------
	// output pairs
	// ----------------------------------------------------------------
	dcd_pair_t out2_reg;
	dcd_pair_t out2_next;
	dcd_pair_t out4_reg;
	dcd_pair_t out4_next;

	always_comb begin
		out2_next = make_pair(div_next[DIV2_BIT]);
		out4_next = make_pair(div_next[DIV4_BIT]);
	end

	// the pin reset clears asynchronously so outputs react without a clock
	always_ff @(posedge CLOCK_I or posedge RESET_I or negedge RESET_N_I) begin
		if (RESET_I || !RESET_N_I) begin
			out2_reg <= '{TRUE_RESET_LEVEL, COMP_RESET_LEVEL};
			out4_reg <= '{TRUE_RESET_LEVEL, COMP_RESET_LEVEL};
		end else begin
			out2_reg <= out2_next;
			out4_reg <= out4_next;
		end
	end

	assign DIVIDED_CLOCK_OUTPUT_2_O = out2_reg.true_out;
	assign DIVIDED_CLOCK_OUTPUT_2_N_O = out2_reg.comp_out;
	assign DIVIDED_CLOCK_OUTPUT_4_O = out4_reg.true_out;
	assign DIVIDED_CLOCK_OUTPUT_4_N_O = out4_reg.comp_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);

	// pair and reset levels
	pair2_inverse_a: assert property (out2_reg.comp_out == ~out2_reg.true_out)
		else $error("div2 complement not inverse");
	pair4_inverse_a: assert property (out4_reg.comp_out == ~out4_reg.true_out)
		else $error("div4 complement not inverse");
	reset_levels_a: assert property (!RESET_N_I |-> !out2_reg.true_out && !out4_reg.true_out)
		else $error("outputs not low in reset");
	comp_reset_a: assert property (!RESET_N_I |-> out2_reg.comp_out && out4_reg.comp_out)
		else $error("complements not high in reset");
	hold_still_a: assert property (RESET_N_I && hold ##1 RESET_N_I |-> div_reg == DIV_RESET)
		else $error("divider ran while held");
	held_low_a: assert property (RESET_N_I && hold ##1 RESET_N_I |->
		!out2_reg.true_out && !out4_reg.true_out)
		else $error("outputs moved while held");

	// divider order
	edge_align_a: assert property ($rose(out4_reg.true_out) |-> $rose(out2_reg.true_out))
		else $error("div4 rise without div2 rise");
	div4_fall_a: assert property (RESET_N_I && $fell(out4_reg.true_out) |->
		$rose(out2_reg.true_out))
		else $error("div4 fell without div2 rise");
	div4_steady_a: assert property (RESET_N_I && $fell(out2_reg.true_out) |->
		$stable(out4_reg.true_out))
		else $error("div4 moved on div2 fall");
	div2_toggle_a: assert property (RESET_N_I && !hold && src_rise |=>
		out2_reg.true_out != $past(out2_reg.true_out))
		else $error("div2 missed an input edge");
	idle_stable_a: assert property (RESET_N_I && !hold && !src_rise ##1 RESET_N_I |->
		$stable(out2_reg) && $stable(out4_reg))
		else $error("outputs moved without an input edge");

	// source path
	select_ttl_a: assert property (is_ttl(st_reg[SYNC_SEL]) |->
		src_clk == st_reg[SYNC_TTL])
		else $error("ttl select wrong");
	ecl_select_a: assert property (!is_ttl(st_reg[SYNC_SEL]) && !st_reg[SYNC_OPEN] |->
		src_clk == (st_reg[SYNC_ECL_P] && !st_reg[SYNC_ECL_N]))
		else $error("ecl select wrong");
	open_pair_a: assert property (st_reg[SYNC_OPEN] && !is_ttl(st_reg[SYNC_SEL]) |->
		!src_clk)
		else $error("open pair not quiet");

	div4_rise_c: cover property ($rose(out4_reg.true_out));
	ttl_run_c: cover property (is_ttl(st_reg[SYNC_SEL]) && $rose(out2_reg.true_out));
	ecl_run_c: cover property (!is_ttl(st_reg[SYNC_SEL]) && $rose(out2_reg.true_out));
	open_pair_c: cover property (st_reg[SYNC_OPEN] && st_reg[SYNC_ECL_P]);
	reset_mid_c: cover property (out4_reg.true_out ##1 !RESET_N_I);

endmodule : dcd_divider

// >>> bench/dcd_sink.sv
// far-side model: processor clock inputs watching the divided clocks
`timescale 1ns/1ps
module dcd_sink (
	// divided clocks from the block
	input wire logic clk2_i,
	input wire logic clk2_n_i,
	input wire logic clk4_i,
	input wire logic clk4_n_i,
	// pair fault seen
	output logic pair_bad_o
);
	// a skewed pair looks like a runt edge to a processor, so flag it
	assign pair_bad_o = (clk2_n_i !== ~clk2_i) || (clk4_n_i !== ~clk4_i);
endmodule : dcd_sink

// >>> bench/tb.sv
// self-checking testbench for the dual input clock divider
`timescale 1ns/1ps
module tb;
	import dcd_pkg::*;
	logic clk = 0, rst = 1, p = 0, n = 1, opn = 0, ttl = 0, sel = SEL_TTL, rst_n = 0;
	logic d2, d2n, d4, d4n, bad, run = 0, d4_last = 0, exp2 = 0;
	logic exp_q[$];
	int n_errors = 0, samples_checked = 0, seed = 67657;
	initial forever #25 clk = ~clk;
	dcd_divider i_dut (.CLOCK_I(clk), .RESET_I(rst), .ECL_PAIR_INPUT_P_I(p),
		.ECL_PAIR_INPUT_N_I(n), .ECL_PAIR_OPEN_I(opn), .TTL_SINGLE_INPUT_I(ttl),
		.SOURCE_SELECT_I(sel), .RESET_N_I(rst_n), .DIVIDED_CLOCK_OUTPUT_2_O(d2),
		.DIVIDED_CLOCK_OUTPUT_2_N_O(d2n), .DIVIDED_CLOCK_OUTPUT_4_O(d4),
		.DIVIDED_CLOCK_OUTPUT_4_N_O(d4n));
	dcd_sink i_sink (.clk2_i(d2), .clk2_n_i(d2n), .clk4_i(d4), .clk4_n_i(d4n),
		.pair_bad_o(bad));
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic stop_test;
		$display("checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	// each level held 5 cycles, above the 2-cycle filter; idle source gets noise
	task automatic level(input logic v);
		@(negedge clk);
		if (sel === SEL_TTL) begin
			ttl = v;
			p = 1'($random(seed));
			n = 1'($random(seed));
		end else begin
			p = v;
			n = ~v;
			ttl = 1'($random(seed));
		end
		repeat (4) @(negedge clk);
	endtask : level
	task automatic pulses(input int k, input logic live);
		repeat (k) begin
			if (live) begin
				exp2 = ~exp2;
				exp_q.push_back(exp2);
			end
			level(1'b1);
			level(1'b0);
		end
	endtask : pulses
	task automatic pick(input logic s);
		@(negedge clk);
		{p, n, ttl, sel} = {3'b010, s};
		repeat (5) @(negedge clk);
	endtask : pick
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 0;
		rst_n = 1;
		repeat (10) @(negedge clk);
		run = 1;
		pulses(6, 1'b1);
		pick(SEL_ECL);
		pulses(6, 1'b1);
		opn = 1;
		pulses(4, 1'b0);
		opn = 0;
		pulses(2, 1'b1);
		@(negedge clk);
		rst_n = 0;
		#1 chk({d2, d2n, d4, d4n} === 4'h5, "reset levels");
		{exp2, d4_last} = 2'b00;
		exp_q.delete();
		pulses(2, 1'b0);
		chk({d2, d2n, d4, d4n} === 4'h5, "reset held");
		rst_n = 1;
		pick(SEL_TTL);
		pulses(8, 1'b1);
		repeat (10) @(negedge clk);
		chk(exp_q.size() == 0, "edge missing");
		stop_test();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// output watcher
	// ----------------------------------------------------------------
	always @(d2) begin
		#1;
		if (run && rst_n === 1'b1) begin
			chk(exp_q.size() > 0 && d2 === exp_q[0], "div2 level");
			if (exp_q.size() > 0) void'(exp_q.pop_front());
			chk(d2 ? d4 !== d4_last : d4 === d4_last, "div4 edge");
			chk(!bad, "pair inverse");
			d4_last = d4;
		end
	end
endmodule : tb
